// ===== rtl/bms_block_move.sv
`timescale 1ns/10ps
`include "bms_regs.svh"
module bms_block_move
  import bms_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // decoder request
  input wire logic START,
  input wire logic WORD_FORM,
  input wire logic [15:0] COUNT_IN,
  input wire logic [15:0] SRC_IN,
  input wire logic [15:0] DST_IN,
  // move status
  output logic BUSY,
  output logic DONE,
  // live registers
  output logic [15:0] COUNT_WORD_REG,
  output logic [15:0] SOURCE_POINTER_REG,
  output logic [15:0] DEST_POINTER_REG,
  // memory bus
  output logic MEM_RD,
  output logic MEM_WR,
  output logic [15:0] MEM_ADDR,
  output logic [7:0] MEM_WDATA,
  // memory read data
  input wire logic [7:0] MEM_RDATA
);
  // ----------------------------------------------------------------
  // timing outline
  // ----------------------------------------------------------------
  // start edge loads form, count and pointers
  // seven fixed states before the first byte
  // zero count: straight to the end state, no bus cycle
  // per byte: read strobe, data into buffer,
  // write set up, write strobe with pointer and count step
  // end state: done for one state, busy drops with it
  // start while busy: ignored, nothing reports it

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  typedef struct packed {
    // sequencing
    bms_state_e state;
    logic word;
    logic [3:0] tick;
    // working registers
    logic [15:0] cnt;
    logic [15:0] src;
    logic [15:0] dst;
    // status and bus strobes
    logic busy;
    logic done;
    logic rd;
    logic wr;
    // bus address and write byte
    logic [15:0] addr;
    logic [7:0] wdata;
  } bms_ctl_s;
  bms_ctl_s st_ff, nxt_st;
  // buffer handshakes
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [7:0] f_out_data;
  // last byte of the move
  logic last;

  // ----------------------------------------------------------------
  // read data buffer
  // ----------------------------------------------------------------
  // data buffer between read and write phases
  bms_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLOCK),
    .rst_n(RST_N),
    .in_valid(f_in_valid),
    .in_data(MEM_RDATA),
    .in_ready(f_in_ready),
    .out_valid(f_out_valid),
    .out_data(f_out_data),
    .out_ready(f_out_ready)
  );

  // ----------------------------------------------------------------
  // buffer handshakes and last byte
  // ----------------------------------------------------------------
  // read data captured on final read state
  assign f_in_valid = (st_ff.state == BMS_READ) && (st_ff.tick == `BMS_RD_STATES - 4'h1);
  assign f_out_ready = (st_ff.state == BMS_WRITE) && (st_ff.tick == 4'h0);
  // count reaches zero after this byte
  // byte form looks at the low count byte only
  assign last = st_ff.word ? (st_ff.cnt == 16'h0001) : (st_ff.cnt[7:0] == 8'h01);

  // ----------------------------------------------------------------
  // next state logic
  // ----------------------------------------------------------------
  // strobes default low, so each lasts one state
  // sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.rd = 1'b0;
    nxt_st.wr = 1'b0;
    case (st_ff.state)
      BMS_IDLE: begin
        // new move taken only while idle
        if (START) begin
          nxt_st.word = WORD_FORM;
          nxt_st.cnt = COUNT_IN;
          nxt_st.src = SRC_IN;
          nxt_st.dst = DST_IN;
          nxt_st.busy = 1'b1;
          nxt_st.tick = 4'h1;
          nxt_st.state = BMS_SETUP;
        end
      end
      BMS_SETUP: begin
        // fixed overhead states
        nxt_st.tick = st_ff.tick + 4'h1;
        if (st_ff.tick == `BMS_SETUP_STATES - 4'h1) begin
          nxt_st.tick = 4'h0;
          // zero count skips the copy entirely
          if (st_ff.word ? (st_ff.cnt == 16'h0000) : (st_ff.cnt[7:0] == 8'h00)) begin
            nxt_st.state = BMS_DONE;
          end else begin
            nxt_st.state = BMS_READ;
            nxt_st.rd = 1'b1;
            nxt_st.addr = st_ff.src;
          end
        end
      end
      BMS_READ: begin
        // strobe went out on entry, wait for the data
        nxt_st.tick = st_ff.tick + 4'h1;
        if (st_ff.tick == `BMS_RD_STATES - 4'h1) begin
          // stall while buffer cannot take the byte
          if (f_in_ready) begin
            // byte buffered, step source
            nxt_st.src = st_ff.src + 16'h0001;
            nxt_st.tick = 4'h0;
            nxt_st.state = BMS_WRITE;
          end else begin
            nxt_st.tick = st_ff.tick;
          end
        end
      end
      BMS_WRITE: begin
        nxt_st.tick = st_ff.tick + 4'h1;
        // first write state: drive the buffered byte out
        if (st_ff.tick == 4'h0) begin
          if (f_out_valid) begin
            nxt_st.wr = 1'b1;
            nxt_st.addr = st_ff.dst;
            nxt_st.wdata = f_out_data;
          end else begin
            // hold until the buffer shows a byte
            nxt_st.tick = st_ff.tick;
          end
        end
        // last write state: step destination and count
        if (st_ff.tick == `BMS_BYTE_STATES - `BMS_RD_STATES - 4'h1) begin
          nxt_st.dst = st_ff.dst + 16'h0001;
          nxt_st.tick = 4'h0;
          // count form decides which bits step
          if (st_ff.word) nxt_st.cnt = st_ff.cnt - 16'h0001;
          else nxt_st.cnt = {st_ff.cnt[15:8], st_ff.cnt[7:0] - 8'h01};
          if (last) begin
            nxt_st.state = BMS_DONE;
          end else begin
            nxt_st.state = BMS_READ;
            nxt_st.rd = 1'b1;
            nxt_st.addr = st_ff.src;
          end
        end
      end
      BMS_DONE: begin
        // end pulse, busy drops with it
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
        nxt_st.state = BMS_IDLE;
      end
      // unused codes fall back to idle
      default: nxt_st.state = BMS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // whole state registered in one place
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      // pointers and count clear on reset
      st_ff <= '0;
      st_ff.state <= BMS_IDLE;
      st_ff.cnt <= `BMS_CNT_RST;
      st_ff.src <= `BMS_PTR_RST;
      st_ff.dst <= `BMS_PTR_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  // outputs from flops
  assign BUSY = st_ff.busy;
  assign DONE = st_ff.done;
  // live registers
  assign COUNT_WORD_REG = st_ff.cnt;
  assign SOURCE_POINTER_REG = st_ff.src;
  assign DEST_POINTER_REG = st_ff.dst;
  // memory bus
  assign MEM_RD = st_ff.rd;
  assign MEM_WR = st_ff.wr;
  assign MEM_ADDR = st_ff.addr;
  assign MEM_WDATA = st_ff.wdata;
endmodule : bms_block_move

// ===== rtl/bms_regs.svh
`ifndef BMS_REGS_SVH
`define BMS_REGS_SVH
`define BMS_SETUP_STATES 4'h8
`define BMS_BYTE_STATES 4'h4
`define BMS_RD_STATES 4'h2
`define BMS_PTR_RST 16'h0000
`define BMS_CNT_RST 16'h0000
`endif

// ===== rtl/bms_pkg.sv
package bms_pkg;
  typedef enum logic [2:0] {
    BMS_IDLE = 3'b000,
    BMS_SETUP = 3'b001,
    BMS_READ = 3'b010,
    BMS_WRITE = 3'b011,
    BMS_DONE = 3'b100
  } bms_state_e;
endpackage : bms_pkg

// ===== rtl/bms_fifo.sv
`timescale 1ns/10ps
module bms_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } bms_fifo_s;
  bms_fifo_s st_ff, nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full, empty;

  // flags from pointers
  assign empty = (st_ff.wp == st_ff.rp);
  assign full = (st_ff.wp[AW] != st_ff.rp[AW]) && (st_ff.wp[AW-1:0] == st_ff.rp[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[st_ff.rp[AW-1:0]];

  // pointer update
  always_comb begin
    nxt_st = st_ff;
    if (in_valid && !full) nxt_st.wp = st_ff.wp + 1'b1;
    if (out_ready && !empty) nxt_st.rp = st_ff.rp + 1'b1;
  end

  // storage write
  always_ff @(posedge clk) begin
    if (in_valid && !full) mem[st_ff.wp[AW-1:0]] <= in_data;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) st_ff <= '0;
    else st_ff <= nxt_st;
  end
endmodule : bms_fifo

// ===== verif/bms_assertions.sv
`timescale 1ns/10ps
module bms_assertions (
  // clock, reset, request
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic START,
  input wire logic WORD_FORM,
  input wire logic [15:0] COUNT_IN,
  // status and memory bus
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic [15:0] COUNT_WORD_REG,
  input wire logic [15:0] SOURCE_POINTER_REG,
  input wire logic [15:0] DEST_POINTER_REG,
  input wire logic MEM_RD,
  input wire logic MEM_WR,
  input wire logic [15:0] MEM_ADDR
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // start of a move with nothing to copy
  logic zs;
  assign zs = START && !BUSY && (WORD_FORM ? COUNT_IN : {8'h00, COUNT_IN[7:0]}) == 16'h0000;
  property p_rd; MEM_RD |-> MEM_ADDR == SOURCE_POINTER_REG; endproperty
  a_rd: assert property (p_rd) else $error("read address wrong");
  property p_wr; MEM_WR |-> MEM_ADDR == DEST_POINTER_REG; endproperty
  a_wr: assert property (p_wr) else $error("write address wrong");
  property p_cnt; MEM_WR |-> ##2 COUNT_WORD_REG == $past(COUNT_WORD_REG, 2) - 16'h0001; endproperty
  a_cnt: assert property (p_cnt) else $error("count not decremented");
  property p_zero; zs |=> !MEM_RD [*8] ##1 DONE; endproperty
  a_zero: assert property (p_zero) else $error("empty move misbehaved");
  property p_next; MEM_WR |-> (##1 MEM_RD) or (##2 DONE); endproperty
  a_next: assert property (p_next) else $error("byte pacing wrong");
  property p_pace; MEM_RD |-> ##3 MEM_WR; endproperty
  a_pace: assert property (p_pace) else $error("read to write spacing wrong");
  property p_done; DONE |-> COUNT_WORD_REG[7:0] == 8'h00 && !BUSY; endproperty
  a_done: assert property (p_done) else $error("count not zero at end");
  c_zero: cover property (zs);
  c_wr: cover property (MEM_WR);
  c_done: cover property (DONE);
  c_word: cover property (START && !BUSY && WORD_FORM && COUNT_IN[15:8] != 8'h00);
endmodule : bms_assertions
bind bms_block_move bms_assertions u_chk (.*);

// ===== verif/bms_mem_model.sv
`timescale 1ns/10ps
module bms_mem_model (
  // clock
  input wire logic clk,
  // memory bus
  input wire logic rd,
  input wire logic wr,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] bytes [65536];
  // preset contents from the address
  initial begin
    for (int i = 0; i < 65536; i++) bytes[i] = i[7:0] ^ i[15:8] ^ 8'ha5;
    rdata = 8'h00;
  end
  // read data one cycle after the pulse, else toggling
  always @(posedge clk) begin
    rdata <= rd ? bytes[addr] : ~rdata;
    if (wr) bytes[addr] <= wdata;
  end
endmodule : bms_mem_model

// ===== verif/tb_bms_block_move.sv
`timescale 1ns/10ps
`define CHK(nm, e, s) begin checks++; if ((e) !== (s)) begin num_errors++; $display("BAD %s exp %h got %h", nm, e, s); end end
module tb_bms_block_move;
  typedef struct packed {logic w; logic [15:0] c; logic [15:0] s; logic [15:0] d; logic [15:0] n; logic [15:0] k;} bms_row_s;
  logic CLOCK = 1'h0, RST_N = 1'h0, START = 1'h0, WORD_FORM = 1'h0;
  logic [15:0] COUNT_IN = 16'h0, SRC_IN = 16'h0, DST_IN = 16'h0;
  logic BUSY, DONE, MEM_RD, MEM_WR;
  logic [15:0] COUNT_WORD_REG, SOURCE_POINTER_REG, DEST_POINTER_REG, MEM_ADDR;
  logic [7:0] MEM_WDATA, MEM_RDATA;
  int num_errors = 0, checks = 0;
  // form, count, source, destination, bytes moved, final count
  bms_row_s rows [6] = '{'{1'h0, 16'h0003, 16'h1000, 16'h2000, 16'h0003, 16'h0000},
    '{1'h1, 16'h0102, 16'h1100, 16'h3000, 16'h0102, 16'h0000},
    '{1'h0, 16'h0502, 16'h1300, 16'h4000, 16'h0002, 16'h0500},
    '{1'h1, 16'h0000, 16'h1400, 16'h4100, 16'h0000, 16'h0000},
    '{1'h0, 16'h0300, 16'h1500, 16'h4200, 16'h0000, 16'h0300},
    '{1'h0, 16'h00ff, 16'hff80, 16'h5000, 16'h00ff, 16'h0000}};
  always #50 CLOCK = ~CLOCK;
  bms_block_move dut (.*);
  bms_mem_model mem (.clk(CLOCK), .rd(MEM_RD), .wr(MEM_WR), .addr(MEM_ADDR), .wdata(MEM_WDATA), .rdata(MEM_RDATA));
  task report_and_stop;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  // one move, optional refused start while busy
  task run(input bms_row_s r, input logic poke);
    int t;
    int n;
    n = r.n;
    @(posedge CLOCK);
    START <= 1'h1;
    WORD_FORM <= r.w;
    COUNT_IN <= r.c;
    SRC_IN <= r.s;
    DST_IN <= r.d;
    @(posedge CLOCK);
    START <= 1'h0;
    for (t = 0; t < 3000; t++) begin
      @(negedge CLOCK);
      if (DONE === 1'h1) break;
      @(posedge CLOCK);
      START <= poke && t == 3;
    end
    if (t == 3000) begin
      num_errors++;
      report_and_stop();
    end
    `CHK("cycles", 8 + 4 * n, t)
    `CHK("count", r.k, COUNT_WORD_REG)
    `CHK("src", 16'(r.s + n), SOURCE_POINTER_REG)
    `CHK("dst", 16'(r.d + n), DEST_POINTER_REG)
    for (int i = 0; i < n; i++) `CHK("byte", 8'(r.s + i) ^ 8'((r.s + i) >> 8) ^ 8'ha5, mem.bytes[16'(r.d + i)])
  endtask : run
  // reset, table rows, then a start refused while busy
  initial begin
    repeat (16) @(posedge CLOCK);
    `CHK("idle", 1'h0, BUSY | DONE | MEM_RD | MEM_WR)
    RST_N <= 1'h1;
    foreach (rows[i]) run(rows[i], 1'h0);
    run('{1'h1, 16'h0004, 16'h1600, 16'h6000, 16'h0004, 16'h0000}, 1'h1);
    report_and_stop();
  end
endmodule : tb_bms_block_move
